// *** rtl/ppf_port_cfg.sv ***
// top of the port pin function configuration block
// assumes lower port-3 latch, direction and mode bits come from a neighbour block
`timescale 1ns/10ps
`default_nettype none

// Function
// - port-3 pins 8,9 open-drain bit: 0 normal use, 1 alternate use
// - configuration registers take whole-byte and single-bit reads and writes
// - pin 5 control bit: 0 timer capture ch1 input, 1 timer ch1 output
// - pin 3 control bit: 0 timer capture ch0 input, 1 timer ch0 output
// - control-mode register resets to zero, read and write at fixed address
// - port-3 pull-up bits 0..5 connect pull-up when 1
// - port-3 pull-up register resets to zero, read and write
// - port 4 has three pins, each with own direction and data
// - port-4 data register 8 bits, read gives pins in input mode and latch in output mode, write sets outputs
// - port-4 mode bits select serial in, out, clock; bits 3..7 read 0
// - port-4 open-drain register picks push-pull or open-drain per pin
// - port-4 pull-up bits 0..2 connect pull-up when 1, reset zero
// - output mode reads latch and drives pin; input mode only latches
// - direction bit 0 means output, 1 input; resets to all ones
module ppf_port_cfg (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        bit_access_i,
  input  wire logic [2:0]  bit_sel_i,
  output logic      [7:0]  rd_data_o,
  input  wire logic [1:0]  p3_latch_i,
  input  wire logic [1:0]  p3_dir_i,
  input  wire logic [1:0]  p3_alt_en_i,
  input  wire logic [1:0]  p3_hi_alt_en_i,
  input  wire logic [1:0]  p3_pin_i,
  output logic      [1:0]  p3_pin_o,
  output logic      [1:0]  p3_pin_oe_o,
  output logic      [1:0]  p3_hi_od_o,
  output logic      [5:0]  p3_pullup_o,
  input  wire logic        timer_out_ch0_i,
  input  wire logic        timer_out_ch1_i,
  output logic             timer_capture_in_ch0_o,
  output logic             timer_capture_in_ch1_o,
  input  wire logic [2:0]  p4_pin_i,
  output logic      [2:0]  p4_pin_o,
  output logic      [2:0]  p4_pin_oe_o,
  output logic      [2:0]  p4_pullup_o,
  input  wire logic        serial_data_out_i,
  input  wire logic        serial_clock_out_i,
  input  wire logic        serial_clock_oe_i,
  output logic             serial_data_in_o,
  output logic             serial_clock_in_o
);

  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0] hi_od;
    logic       cap0;
    logic       cap1;
    logic       sdi;
    logic       sck_in;
  } ppf_top_s;

  ppf_top_s                          st_q;
  ppf_top_s                          st_d;
  logic     [ppf_pkg::NREG-1:0][7:0] regs;
  logic     [ppf_pkg::NREG-1:0]      hit;
  logic     [1:0]                    p3_sync;
  logic     [2:0]                    p4_sync;
  logic     [1:0]                    p3_ctrl;
  logic     [1:0]                    p3_tmr_out;
  logic     [2:0]                    p4_alt_out;
  logic     [2:0]                    p4_alt_oe;
  logic     [7:0]                    rd_byte;
  logic     [7:0]                    p4_read;

  // ****************************************************************
  // register file
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < ppf_pkg::NREG; gi++) begin : g_reg
      assign hit[gi] = (addr_i == ppf_pkg::REG_OFF[gi]);
      ppf_bit_reg #(
        .MASK  (ppf_pkg::REG_MASK[gi]),
        .RESET (ppf_pkg::REG_RST[gi])
      ) u_reg (
        .clock_i      (clock_i),
        .rst_i        (rst_i),
        .wr_i         (wr_i & hit[gi]),
        .bit_access_i (bit_access_i),
        .bit_sel_i    (bit_sel_i),
        .wr_data_i    (wr_data_i),
        .q_o          (regs[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // port-3 timer pins 3 and 5
  // ****************************************************************
  // pin 3 and pin 5 selection
  assign p3_ctrl[0]    = regs[ppf_pkg::IDX_P3_CTRLMODE][ppf_pkg::PIN3_CTRL_BIT];
  assign p3_ctrl[1]    = regs[ppf_pkg::IDX_P3_CTRLMODE][ppf_pkg::PIN5_CTRL_BIT];
  assign p3_tmr_out    = {timer_out_ch1_i, timer_out_ch0_i};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_p3
      ppf_pin_cell u_cell (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .pin_i      (p3_pin_i[gi]),
        .latch_i    (p3_latch_i[gi]),
        .dir_i      (p3_dir_i[gi]),
        .alt_en_i   (p3_alt_en_i[gi]),
        .alt_out_i  (p3_tmr_out[gi]),
        .alt_oe_i   (p3_ctrl[gi]),
        .od_en_i    (1'b0),
        .pin_o      (p3_pin_o[gi]),
        .pin_oe_o   (p3_pin_oe_o[gi]),
        .pin_sync_o (p3_sync[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // port-4 pins
  // ****************************************************************
  // serial routing
  assign p4_alt_out = {serial_clock_out_i, serial_data_out_i, 1'b0};
  assign p4_alt_oe  = {serial_clock_oe_i, 1'b1, 1'b0};

  generate
    for (gi = 0; gi < ppf_pkg::P4_PINS; gi++) begin : g_p4
      ppf_pin_cell u_cell (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .pin_i      (p4_pin_i[gi]),
        .latch_i    (regs[ppf_pkg::IDX_P4_LATCH][gi]),
        .dir_i      (regs[ppf_pkg::IDX_P4_DIR][gi]),
        .alt_en_i   (regs[ppf_pkg::IDX_P4_ALT][gi]),
        .alt_out_i  (p4_alt_out[gi]),
        .alt_oe_i   (p4_alt_oe[gi]),
        .od_en_i    (regs[ppf_pkg::IDX_P4_OD][gi]),
        .pin_o      (p4_pin_o[gi]),
        .pin_oe_o   (p4_pin_oe_o[gi]),
        .pin_sync_o (p4_sync[gi])
      );
    end
  endgenerate

  // pins in input mode, latch in output mode
  assign p4_read = {5'h00, (regs[ppf_pkg::IDX_P4_DIR][2:0] & p4_sync)
                         | (~regs[ppf_pkg::IDX_P4_DIR][2:0] & regs[ppf_pkg::IDX_P4_LATCH][2:0])};

  // ****************************************************************
  // read path and derived outputs
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    rd_byte = 8'h00;
    for (int i = 0; i < ppf_pkg::NREG; i++) begin
      if (hit[i]) begin
        rd_byte = (i == ppf_pkg::IDX_P4_LATCH) ? p4_read : regs[i];
      end
    end
    if (bit_access_i) begin
      rd_byte = {7'h00, rd_byte[bit_sel_i]};
    end
    st_d.rdata = rd_i ? rd_byte : 8'h00;
    st_d.hi_od  = ~(regs[ppf_pkg::IDX_P3_HI_OD][1:0] ^ p3_hi_alt_en_i);
    st_d.cap0   = p3_alt_en_i[0] & ~p3_ctrl[0] & p3_sync[0];
    st_d.cap1   = p3_alt_en_i[1] & ~p3_ctrl[1] & p3_sync[1];
    st_d.sdi    = regs[ppf_pkg::IDX_P4_ALT][ppf_pkg::P4_DATAIN_BIT] & p4_sync[ppf_pkg::P4_DATAIN_BIT];
    st_d.sck_in = regs[ppf_pkg::IDX_P4_ALT][ppf_pkg::P4_CLOCK_BIT] & p4_sync[ppf_pkg::P4_CLOCK_BIT];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data_o              = st_q.rdata;
  assign p3_hi_od_o             = st_q.hi_od;
  assign timer_capture_in_ch0_o = st_q.cap0;
  assign timer_capture_in_ch1_o = st_q.cap1;
  assign serial_data_in_o       = st_q.sdi;
  assign serial_clock_in_o      = st_q.sck_in;
  assign p3_pullup_o            = regs[ppf_pkg::IDX_P3_PULLUP][ppf_pkg::P3_PULLUPS-1:0];
  assign p4_pullup_o            = regs[ppf_pkg::IDX_P4_PULLUP][ppf_pkg::P4_PINS-1:0];

endmodule

`default_nettype wire

// *** rtl/ppf_pkg.sv ***
// constants for the port pin function configuration block
// assumes a byte-wide register port with printed addresses used directly
package ppf_pkg;

  // ****************************************************************
  // register file layout
  // ****************************************************************
  localparam int unsigned NREG = 8;

  localparam int unsigned IDX_P3_PULLUP   = 0;
  localparam int unsigned IDX_P4_ALT      = 1;
  localparam int unsigned IDX_P3_CTRLMODE = 2;
  localparam int unsigned IDX_P4_PULLUP   = 3;
  localparam int unsigned IDX_P3_HI_OD    = 4;
  localparam int unsigned IDX_P4_LATCH    = 5;
  localparam int unsigned IDX_P4_DIR      = 6;
  localparam int unsigned IDX_P4_OD       = 7;

  localparam logic [NREG-1:0][31:0] REG_OFF = {
    32'hfffffc68,  // port4_open_drain_select
    32'hfffff428,  // port4_direction
    32'hfffff408,  // port4_data_latch
    32'hfffff477,  // port3_upper_open_drain
    32'hfffffc48,  // port4_pullup_enable
    32'hfffff466,  // port3_control_mode_select
    32'hfffff448,  // port4_alt_function_enable
    32'h0ffffc46   // port3_pullup_enable
  };

  // bits that hold state; all other bits read their reset value
  localparam logic [NREG-1:0][7:0] REG_MASK = {
    8'h07, 8'h07, 8'h07, 8'h03, 8'h07, 8'h28, 8'h07, 8'h3f
  };

  localparam logic [NREG-1:0][7:0] REG_RST = {
    8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned PIN3_CTRL_BIT = 3;
  localparam int unsigned PIN5_CTRL_BIT = 5;
  localparam int unsigned P4_DATAIN_BIT = 0;
  localparam int unsigned P4_DOUT_BIT   = 1;
  localparam int unsigned P4_CLOCK_BIT  = 2;
  localparam int unsigned P3_PULLUPS    = 6;
  localparam int unsigned P4_PINS       = 3;

endpackage

// *** rtl/ppf_bit_reg.sv ***
// one 8-bit configuration register with whole-byte and single-bit writes
// assumes the select strobe is already decoded on the same clock
`timescale 1ns/10ps
`default_nettype none

module ppf_bit_reg #(
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire logic       bit_access_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] q_o
);

  typedef struct packed {
    logic [7:0] val;
  } ppf_reg_s;

  ppf_reg_s st_q;
  ppf_reg_s st_d;

  // ****************************************************************
  // byte or bit merge
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    if (wr_i) begin
      if (bit_access_i) begin
        st_d.val[bit_sel_i] = wr_data_i[0];
      end else begin
        st_d.val = wr_data_i;
      end
    end
    st_d.val = (st_d.val & MASK) | (RESET & ~MASK);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= '{val: RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign q_o = st_q.val;

endmodule

`default_nettype wire

// *** rtl/ppf_pin_cell.sv ***
// one pin: input synchroniser and registered output and enable
// assumes an outside pad resolves the wire from output and enable
`timescale 1ns/10ps
`default_nettype none

module ppf_pin_cell (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  input  wire logic latch_i,
  input  wire logic dir_i,
  input  wire logic alt_en_i,
  input  wire logic alt_out_i,
  input  wire logic alt_oe_i,
  input  wire logic od_en_i,
  output logic      pin_o,
  output logic      pin_oe_o,
  output logic      pin_sync_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic out;
    logic oe;
  } ppf_cell_s;

  ppf_cell_s st_q;
  ppf_cell_s st_d;
  logic      drive;
  logic      val;

  // ****************************************************************
  // pin drive
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    st_d.meta = pin_i;
    st_d.sync = st_q.meta;
    drive = alt_en_i ? alt_oe_i : ~dir_i;
    val = alt_en_i ? alt_out_i : latch_i;
    st_d.out = val;
    st_d.oe = drive & ~(od_en_i & val);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_o      = st_q.out;
  assign pin_oe_o   = st_q.oe;
  assign pin_sync_o = st_q.sync;

endmodule

`default_nettype wire

// *** tb/ppf_port_cfg_asserts.sv ***
// checker for the port pin function configuration block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module ppf_port_cfg_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        bit_access_i,
  input wire logic [2:0]  bit_sel_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic [1:0]  p3_latch_i,
  input wire logic [1:0]  p3_dir_i,
  input wire logic [1:0]  p3_alt_en_i,
  input wire logic [1:0]  p3_pin_o,
  input wire logic [1:0]  p3_pin_oe_o,
  input wire logic [5:0]  p3_pullup_o,
  input wire logic [2:0]  p4_pullup_o
);
  localparam logic [31:0] A_P3MODE = 32'hfffff466;
  localparam logic [31:0] A_P3PULL = 32'h0ffffc46;
  localparam logic [31:0] A_P4PULL = 32'hfffffc48;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ****
  // properties
  // ****
  rd_idle_a: assert property (
    !rd_i |=> rd_data_o == 8'h00) else $error("read data not idle");
  pull_reset_a: assert property (
    $fell(rst_i) |-> p3_pullup_o == 6'h00 && p4_pullup_o == 3'h0) else $error("pull-up not reset");
  mode_readback_a: assert property (
    wr_i && !bit_access_i && addr_i == A_P3MODE ##1 rd_i && !bit_access_i && addr_i == A_P3MODE
    |=> rd_data_o == ($past(wr_data_i, 2) & 8'h28)) else $error("mode readback wrong");
  p3_pull_wr_a: assert property (
    wr_i && !bit_access_i && addr_i == A_P3PULL |=> p3_pullup_o == $past(wr_data_i[5:0]))
    else $error("pull-up byte write lost");
  bit_write_a: assert property (
    wr_i && bit_access_i && addr_i == A_P3PULL && bit_sel_i < 3'h6
    |=> p3_pullup_o[$past(bit_sel_i)] == $past(wr_data_i[0])) else $error("bit write lost");
  p4_pull_wr_a: assert property (
    wr_i && !bit_access_i && addr_i == A_P4PULL |=> p4_pullup_o == $past(wr_data_i[2:0]))
    else $error("port4 pull-up write lost");
  unmapped_read_a: assert property (
    rd_i && addr_i == 32'hfffff400 |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
  dir_enable_a: assert property (
    !rst_i && !p3_alt_en_i[0] |=> p3_pin_oe_o[0] == !$past(p3_dir_i[0]))
    else $error("direction not applied");
  latch_drive_a: assert property (
    !rst_i && !p3_alt_en_i[1] && !p3_dir_i[1] |=> p3_pin_o[1] == $past(p3_latch_i[1]))
    else $error("latch not driven");

  cover property (wr_i && bit_access_i);
  cover property (wr_i && addr_i == A_P3MODE ##1 rd_i && addr_i == A_P3MODE);
  cover property (rd_i && addr_i == 32'hfffff400);
endmodule

bind ppf_port_cfg ppf_port_cfg_chk u_chk (
  .clock_i      (clock_i),
  .rst_i        (rst_i),
  .addr_i       (addr_i),
  .wr_data_i    (wr_data_i),
  .wr_i         (wr_i),
  .rd_i         (rd_i),
  .bit_access_i (bit_access_i),
  .bit_sel_i    (bit_sel_i),
  .rd_data_o    (rd_data_o),
  .p3_latch_i   (p3_latch_i),
  .p3_dir_i     (p3_dir_i),
  .p3_alt_en_i  (p3_alt_en_i),
  .p3_pin_o     (p3_pin_o),
  .p3_pin_oe_o  (p3_pin_oe_o),
  .p3_pullup_o  (p3_pullup_o),
  .p4_pullup_o  (p4_pullup_o)
);

`default_nettype wire

// *** tb/ppf_pad_model.sv ***
// pad and far-side model: pin levels, pull-ups and outside drivers
// assumes the bench says which pins an outside driver holds
`timescale 1ns/10ps
`default_nettype none

module ppf_pad_model (
  input  wire logic       clock_i,
  input  wire logic [1:0] p3_pin_o,
  input  wire logic [1:0] p3_pin_oe_o,
  input  wire logic [5:0] p3_pullup_o,
  input  wire logic [2:0] p4_pin_o,
  input  wire logic [2:0] p4_pin_oe_o,
  input  wire logic [2:0] p4_pullup_o,
  input  wire logic [4:0] ext_en_i,
  input  wire logic [4:0] ext_val_i,
  output logic      [1:0] p3_pin_i,
  output logic      [2:0] p4_pin_i
);
  logic [4:0] oe;
  logic [4:0] lv;
  logic [4:0] pu;
  logic [4:0] fl = 5'h0a;

  assign oe = {p4_pin_oe_o, p3_pin_oe_o};
  assign lv = {p4_pin_o, p3_pin_o};
  assign pu = {p4_pullup_o, p3_pullup_o[5], p3_pullup_o[3]};
  always @(posedge clock_i) fl <= ~fl;
  assign {p4_pin_i, p3_pin_i} = (oe & lv) | (~oe & ext_en_i & ext_val_i) | (~oe & ~ext_en_i & (pu | fl));
endmodule

`default_nettype wire

// *** tb/tb_ppf_port_cfg.sv ***
// testbench for the port pin function configuration block
// assumes the pad model resolves every pin level
`timescale 1ns/10ps
`default_nettype none

module tb_ppf_port_cfg;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] addr_i = 32'h0;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        bit_access_i = 1'b0;
  logic [2:0]  bit_sel_i = 3'h0;
  logic [1:0]  p3_latch_i = 2'h0, p3_dir_i = 2'h3, p3_alt_en_i = 2'h0, p3_hi_alt_en_i = 2'h0;
  logic        timer_out_ch0_i = 1'b0, timer_out_ch1_i = 1'b0;
  logic        serial_data_out_i = 1'b0, serial_clock_out_i = 1'b0, serial_clock_oe_i = 1'b0;
  logic [4:0]  ext_en_i = 5'h00, ext_val_i = 5'h00;
  logic [7:0]  rd_data_o;
  logic [1:0]  p3_pin_i, p3_pin_o, p3_pin_oe_o, p3_hi_od_o;
  logic [5:0]  p3_pullup_o;
  logic [2:0]  p4_pin_i, p4_pin_o, p4_pin_oe_o, p4_pullup_o;
  logic        timer_capture_in_ch0_o, timer_capture_in_ch1_o, serial_data_in_o, serial_clock_in_o;
  int          n_fail = 0, total_checks = 0;
  localparam logic [31:0] A_P3PULL = 32'h0ffffc46, A_P4ALT = 32'hfffff448, A_P3MODE = 32'hfffff466;
  localparam logic [31:0] A_P4PULL = 32'hfffffc48, A_P3HIOD = 32'hfffff477, A_P4LAT = 32'hfffff408;
  localparam logic [31:0] A_P4DIR = 32'hfffff428, A_P4OD = 32'hfffffc68;
  localparam logic [31:0] ra [6] = '{A_P3PULL, A_P4ALT, A_P3MODE, A_P4PULL, A_P4DIR, A_P3HIOD};
  localparam logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
  localparam logic [7:0]  rm [6] = '{8'h3f, 8'h07, 8'h28, 8'h07, 8'hff, 8'h03};
  // software keeps unused control-mode bits at zero
  localparam logic [7:0]  wv [6] = '{8'hff, 8'hff, 8'h28, 8'hff, 8'hff, 8'hff};

  ppf_port_cfg u_dut (
    .clock_i                (clock_i),
    .rst_i                  (rst_i),
    .addr_i                 (addr_i),
    .wr_data_i              (wr_data_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .bit_access_i           (bit_access_i),
    .bit_sel_i              (bit_sel_i),
    .rd_data_o              (rd_data_o),
    .p3_latch_i             (p3_latch_i),
    .p3_dir_i               (p3_dir_i),
    .p3_alt_en_i            (p3_alt_en_i),
    .p3_hi_alt_en_i         (p3_hi_alt_en_i),
    .p3_pin_i               (p3_pin_i),
    .p3_pin_o               (p3_pin_o),
    .p3_pin_oe_o            (p3_pin_oe_o),
    .p3_hi_od_o             (p3_hi_od_o),
    .p3_pullup_o            (p3_pullup_o),
    .timer_out_ch0_i        (timer_out_ch0_i),
    .timer_out_ch1_i        (timer_out_ch1_i),
    .timer_capture_in_ch0_o (timer_capture_in_ch0_o),
    .timer_capture_in_ch1_o (timer_capture_in_ch1_o),
    .p4_pin_i               (p4_pin_i),
    .p4_pin_o               (p4_pin_o),
    .p4_pin_oe_o            (p4_pin_oe_o),
    .p4_pullup_o            (p4_pullup_o),
    .serial_data_out_i      (serial_data_out_i),
    .serial_clock_out_i     (serial_clock_out_i),
    .serial_clock_oe_i      (serial_clock_oe_i),
    .serial_data_in_o       (serial_data_in_o),
    .serial_clock_in_o      (serial_clock_in_o)
  );

  ppf_pad_model u_pad (
    .clock_i     (clock_i),
    .p3_pin_o    (p3_pin_o),
    .p3_pin_oe_o (p3_pin_oe_o),
    .p3_pullup_o (p3_pullup_o),
    .p4_pin_o    (p4_pin_o),
    .p4_pin_oe_o (p4_pin_oe_o),
    .p4_pullup_o (p4_pullup_o),
    .ext_en_i    (ext_en_i),
    .ext_val_i   (ext_val_i),
    .p3_pin_i    (p3_pin_i),
    .p4_pin_i    (p4_pin_i)
  );

  always #2.5 clock_i = ~clock_i;

  // ****
  // tasks
  // ****
  task automatic ck(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic b, input logic [2:0] s, input logic [7:0] d);
    addr_i <= a;
    bit_access_i <= b;
    bit_sel_i <= s;
    wr_data_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [31:0] a, input logic b, input logic [2:0] s, input logic [7:0] e);
    addr_i <= a;
    bit_access_i <= b;
    bit_sel_i <= s;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 ck(rd_data_o, e);
    @(posedge clock_i);
  endtask

  task automatic wt(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #10000;
    n_fail++;
    stop_test;
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], 1'b0, 3'h0, rv[i]);
    foreach (ra[i]) begin
      wr(ra[i], 1'b0, 3'h0, wv[i]);
      rd(ra[i], 1'b0, 3'h0, rm[i]);
    end
    rd(32'hfffff400, 1'b0, 3'h0, 8'h00);
    $display("test registers done");
    wr(A_P3PULL, 1'b1, 3'h2, 8'h00);
    rd(A_P3PULL, 1'b0, 3'h0, 8'h3b);
    rd(A_P3PULL, 1'b1, 3'h3, 8'h01);
    wr(A_P3PULL, 1'b1, 3'h2, 8'h01);
    wt(2);
    ck({2'h0, p3_pullup_o}, 8'h3f);
    ck({5'h0, p4_pullup_o}, 8'h07);
    $display("test bit access done");
    wr(A_P4ALT, 1'b0, 3'h0, 8'h00);
    wr(A_P4DIR, 1'b0, 3'h0, 8'h00);
    wr(A_P4LAT, 1'b0, 3'h0, 8'h05);
    wt(3);
    ck({2'h0, p4_pin_oe_o, p4_pin_o}, 8'h3d);
    rd(A_P4LAT, 1'b0, 3'h0, 8'h05);
    ext_en_i <= 5'h1c;
    ext_val_i <= 5'h18;
    wr(A_P4DIR, 1'b0, 3'h0, 8'hff);
    wr(A_P4LAT, 1'b0, 3'h0, 8'h01);
    wt(4);
    ck({5'h0, p4_pin_oe_o}, 8'h00);
    rd(A_P4LAT, 1'b0, 3'h0, 8'h06);
    $display("test port pins done");
    ext_en_i <= 5'h04;
    ext_val_i <= 5'h04;
    serial_clock_oe_i <= 1'b1;
    serial_clock_out_i <= 1'b1;
    wr(A_P4ALT, 1'b0, 3'h0, 8'h07);
    wr(A_P4OD, 1'b0, 3'h0, 8'h02);
    wt(5);
    ck({3'h0, p4_pin_oe_o, serial_data_in_o, serial_clock_in_o}, 8'h1b);
    serial_data_out_i <= 1'b1;
    wt(3);
    ck({5'h0, p4_pin_oe_o}, 8'h04);
    $display("test serial done");
    p3_alt_en_i <= 2'h3;
    timer_out_ch0_i <= 1'b1;
    wr(A_P3MODE, 1'b0, 3'h0, 8'h28);
    wt(4);
    ck({2'h0, p3_pin_oe_o, p3_pin_o, timer_capture_in_ch1_o, timer_capture_in_ch0_o}, 8'h34);
    ext_en_i <= 5'h07;
    ext_val_i <= 5'h06;
    wr(A_P3MODE, 1'b1, 3'h5, 8'h00);
    wr(A_P3MODE, 1'b1, 3'h3, 8'h00);
    wt(5);
    ck({4'h0, p3_pin_oe_o, timer_capture_in_ch1_o, timer_capture_in_ch0_o}, 8'h02);
    ext_val_i <= 5'h05;
    wt(4);
    ck({6'h0, timer_capture_in_ch1_o, timer_capture_in_ch0_o}, 8'h01);
    $display("test timer done");
    ext_en_i <= 5'h04;
    p3_alt_en_i <= 2'h0;
    p3_dir_i <= 2'h0;
    p3_latch_i <= 2'h2;
    wt(3);
    ck({4'h0, p3_pin_oe_o, p3_pin_o}, 8'h0e);
    wr(A_P3HIOD, 1'b0, 3'h0, 8'h01);
    wt(1);
    p3_hi_alt_en_i <= 2'h1;
    wt(3);
    ck({6'h0, p3_hi_od_o}, 8'h03);
    wr(A_P3HIOD, 1'b0, 3'h0, 8'h02);
    wt(3);
    ck({6'h0, p3_hi_od_o}, 8'h00);
    $display("test open drain done");
    rst_i <= 1'b1;
    wt(3);
    rst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], 1'b0, 3'h0, rv[i]);
    ck({2'h0, p3_pullup_o}, 8'h00);
    ck({6'h0, p3_hi_od_o}, 8'h02);
    $display("test mid-run reset done");
    stop_test;
  end
endmodule

`default_nettype wire
